// [cpu_bus_if.sv]
// External memory and serial I/O bus interface of the processor
//
// Notes on behaviour
// - Fifteen-bit word address out, line zero is the most significant bit.
// - Memory-cycle qualifier active means address lines carry a memory word address.
// - Qualifier inactive means address lines carry the serial I/O bit address.
// - Sixteen-bit two-way data bus, line zero is the most significant bit.
// - Memory writes drive data out; memory reads take data from memory.
// - While bus release is acknowledged, address and data lines float high.
// - On memory reads raise read direction and stop driving data.
// - Read direction stays low otherwise, but is high during bus release.
// - Memory-cycle qualifier is low exactly while a memory address is out.
// - Write strobe is low while write data is driven toward memory.
// - Serial strobe pulses high for output data or an external code.
// - Input operations sample the serial input bit at the given address.
// - Output operations drive serial data, captured when the strobe rises.
// - Release request is granted after the current memory cycle; work resumes later.
// - Without ready the processor waits, raises wait and suspends.
`default_nettype none
module cpu_bus_if (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Core memory request
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [14:0] mem_addr_i,
  input  wire logic [15:0] mem_wdata_i,
  // Core serial request
  input  wire logic        ser_req_i,
  input  wire logic [1:0]  ser_op_i,
  input  wire logic [11:0] ser_addr_i,
  input  wire logic        ser_out_bit_i,
  input  wire logic [2:0]  ext_code_i,
  // Core answers
  output var  logic        done_o,
  output var  logic [15:0] rdata_o,
  output var  logic        ser_in_bit_o,
  // Address and data pins
  output var  logic [0:14] addr_o,
  output var  logic [0:15] data_o,
  output var  logic [0:15] data_oe_o,
  input  wire logic [0:15] data_i,
  // Bus control pins
  output var  logic        memory_cycle_n_o,
  output var  logic        read_direction_o,
  output var  logic        write_en_n_o,
  output var  logic        wait_o,
  input  wire logic        ready_i,
  input  wire logic        bus_release_req_n_i,
  output var  logic        bus_release_ack_o,
  // Serial I/O pins
  output var  logic        serial_io_strobe_o,
  output var  logic        serial_io_out_o,
  input  wire logic        serial_io_in_i
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_MEM, ST_SER_SET, ST_SER_STROBE, ST_SER_WAIT, ST_HOLD
  } bus_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic        ready_s;
  logic        hold_n_s;
  logic        ser_in_s;
  logic [15:0] data_s;

  pin_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_ctl_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({ready_i, bus_release_req_n_i, serial_io_in_i}),
    .sync_o     ({ready_s, hold_n_s, ser_in_s})
  );

  pin_sync #(.WIDTH(16), .RST_VAL(16'h0000)) u_data_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (data_i),
    .sync_o     (data_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  bus_state_e  state_q, state_d;
  logic        we_q, we_d;
  logic [14:0] maddr_q, maddr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [1:0]  op_q, op_d;
  logic [14:0] saddr_q, saddr_d;
  logic        sbit_q, sbit_d;
  logic [1:0]  cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    we_d    = we_q;
    maddr_d = maddr_q;
    wdata_d = wdata_q;
    op_d    = op_q;
    saddr_d = saddr_q;
    sbit_d  = sbit_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (!hold_n_s) begin
          state_d = ST_HOLD;
        end else if (mem_req_i) begin
          state_d = ST_MEM;
          we_d    = mem_we_i;
          maddr_d = mem_addr_i;
          wdata_d = mem_wdata_i;
        end else if (ser_req_i) begin
          state_d = ST_SER_SET;
          op_d    = ser_op_i;
          sbit_d  = ser_out_bit_i;
          saddr_d = {(ser_op_i == cpu_bus_pkg::SER_OP_EXT) ? ext_code_i
                                                           : cpu_bus_pkg::SER_CODE_NONE,
                     ser_addr_i};
        end
      end
      ST_MEM: begin
        if (ready_s) begin
          state_d = ST_IDLE;
        end
      end
      ST_SER_SET: begin
        cnt_d   = cpu_bus_pkg::SER_SETTLE_CYC;
        state_d = (op_q == cpu_bus_pkg::SER_OP_INPUT) ? ST_SER_WAIT : ST_SER_STROBE;
      end
      ST_SER_STROBE: begin
        state_d = ST_IDLE;
      end
      ST_SER_WAIT: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (hold_n_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      we_q    <= 1'b0;
      maddr_q <= cpu_bus_pkg::ADDR_RELEASED;
      wdata_q <= cpu_bus_pkg::DATA_RELEASED;
      op_q    <= cpu_bus_pkg::SER_OP_INPUT;
      saddr_q <= cpu_bus_pkg::ADDR_RELEASED;
      sbit_q  <= 1'b1;
      cnt_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      we_q    <= we_d;
      maddr_q <= maddr_d;
      wdata_q <= wdata_d;
      op_q    <= op_d;
      saddr_q <= saddr_d;
      sbit_q  <= sbit_d;
      cnt_q   <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, registered from the next state; wait is registered from the current state

  logic mem_d;
  logic ser_d;
  logic rel_d;
  assign mem_d = (state_d == ST_MEM);
  assign ser_d = (state_d == ST_SER_SET) || (state_d == ST_SER_STROBE) ||
                 (state_d == ST_SER_WAIT);
  assign rel_d = (state_d == ST_HOLD);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o            <= cpu_bus_pkg::ADDR_RELEASED;
      data_o            <= cpu_bus_pkg::DATA_RELEASED;
      data_oe_o         <= cpu_bus_pkg::DATA_OE_NONE;
      memory_cycle_n_o  <= 1'b1;
      read_direction_o  <= 1'b0;
      write_en_n_o      <= 1'b1;
      bus_release_ack_o <= 1'b0;
    end else if (rel_d) begin
      addr_o            <= cpu_bus_pkg::ADDR_RELEASED;
      data_o            <= cpu_bus_pkg::DATA_RELEASED;
      data_oe_o         <= cpu_bus_pkg::DATA_OE_NONE;
      memory_cycle_n_o  <= 1'b1;
      read_direction_o  <= 1'b1;
      write_en_n_o      <= 1'b1;
      bus_release_ack_o <= 1'b1;
    end else begin
      addr_o            <= mem_d ? maddr_d : saddr_d;
      data_o            <= (mem_d && we_d) ? wdata_d : cpu_bus_pkg::DATA_RELEASED;
      data_oe_o         <= (mem_d && we_d) ? cpu_bus_pkg::DATA_OE_ALL
                                           : cpu_bus_pkg::DATA_OE_NONE;
      memory_cycle_n_o  <= !mem_d;
      read_direction_o  <= mem_d && !we_d;
      write_en_n_o      <= !(mem_d && we_d);
      bus_release_ack_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_io_strobe_o <= 1'b0;
      serial_io_out_o    <= 1'b1;
      wait_o             <= 1'b0;
    end else begin
      serial_io_strobe_o <= (state_d == ST_SER_STROBE);
      serial_io_out_o    <= (ser_d && op_d == cpu_bus_pkg::SER_OP_OUTPUT) ? sbit_d : 1'b1;
      wait_o             <= (state_q == ST_MEM) && !ready_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core answers

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o       <= 1'b0;
      rdata_o      <= cpu_bus_pkg::RDATA_RST;
      ser_in_bit_o <= 1'b0;
    end else begin
      done_o <= (state_q != ST_IDLE) && (state_q != ST_HOLD) && (state_d == ST_IDLE);
      if (state_q == ST_MEM && ready_s && !we_q) begin
        rdata_o <= data_s;
      end
      if (state_q == ST_SER_WAIT && cnt_q == 2'h1) begin
        ser_in_bit_o <= ser_in_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_release_floats_bus: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bus_release_ack_o |-> (addr_o == cpu_bus_pkg::ADDR_RELEASED) && (data_oe_o == '0)
      && memory_cycle_n_o && write_en_n_o && read_direction_o)
    else $error("bus not released during acknowledge");

  a_read_no_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (read_direction_o && !bus_release_ack_o) |-> (data_oe_o == '0) && !memory_cycle_n_o
      && write_en_n_o)
    else $error("data driven during read");

  a_dir_low_otherwise: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!bus_release_ack_o && (memory_cycle_n_o || !write_en_n_o)) |-> !read_direction_o)
    else $error("read direction high outside read");

  a_write_drives_data: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !write_en_n_o |-> (data_oe_o == '1) && !memory_cycle_n_o)
    else $error("write strobe without data drive");

  a_strobe_one_cycle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(serial_io_strobe_o) |=> !serial_io_strobe_o && memory_cycle_n_o)
    else $error("serial strobe not a single pulse");

  a_strobe_io_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    serial_io_strobe_o |-> memory_cycle_n_o && $stable(addr_o) && $stable(serial_io_out_o))
    else $error("serial data or address moved at strobe");

  a_wait_in_mem: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wait_o |-> !memory_cycle_n_o && $past(!ready_s))
    else $error("wait without pending memory cycle");

  a_hold_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_IDLE && !hold_n_s) |=> bus_release_ack_o)
    else $error("release not acknowledged");

  a_mem_done_timing: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_MEM && ready_s) |=> done_o && memory_cycle_n_o)
    else $error("memory cycle did not end on ready");

  a_input_sample: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_SER_SET && op_q == cpu_bus_pkg::SER_OP_INPUT) |-> ##4 done_o
      && memory_cycle_n_o)
    else $error("serial input not sampled in time");

endmodule // cpu_bus_if
`default_nettype wire

// [cpu_bus_pkg.sv]
// Package of bus constants and the two-flop pin synchroniser
`default_nettype none
package cpu_bus_pkg;
  localparam int unsigned ADDR_W           = 15;
  localparam int unsigned DATA_W           = 16;
  localparam int unsigned SER_ADDR_W       = 12;
  localparam int unsigned SER_CODE_W       = 3;
  // Serial operation codes
  localparam logic [1:0]  SER_OP_INPUT     = 2'h0;
  localparam logic [1:0]  SER_OP_OUTPUT    = 2'h1;
  localparam logic [1:0]  SER_OP_EXT       = 2'h2;
  // Released pin levels, data output enables and the empty serial code
  localparam logic [14:0] ADDR_RELEASED    = 15'h7FFF;
  localparam logic [15:0] DATA_RELEASED    = 16'hFFFF;
  localparam logic [15:0] DATA_OE_ALL      = 16'hFFFF;
  localparam logic [15:0] DATA_OE_NONE     = 16'h0000;
  localparam logic [2:0]  SER_CODE_NONE    = 3'h0;
  // Reset values
  localparam logic [15:0] RDATA_RST        = 16'h0000;
  localparam logic [1:0]  SYNC_RST         = 2'h0;
  // Cycles the serial input is given to settle and pass the synchroniser
  localparam logic [1:0]  SER_SETTLE_CYC   = 2'h3;
endpackage : cpu_bus_pkg

////////////////////////////////////////////////////////////////////////////////

module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Pin side and synchronised side
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// [mem_model.sv]
// Far-side model: memory with ready, bus pull-ups and serial I/O logic
`default_nettype none
module mem_model (
  // Clock and mode
  input  wire logic        core_clk_i,
  input  wire logic        slow_i,
  // Memory bus pins
  input  wire logic [0:14] addr_i,
  input  wire logic [0:15] dout_i,
  input  wire logic [0:15] doe_i,
  input  wire logic        mcyc_n_i,
  input  wire logic        rdir_i,
  input  wire logic        we_n_i,
  output var  logic [0:15] bus_o,
  output var  logic        ready_o,
  // Serial pins
  input  wire logic        strobe_i,
  input  wire logic        sout_i,
  output var  logic        sin_o,
  output var  logic        cap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [16];
  logic [3:0]  cnt_q;
  logic        rd;
  assign rd = rdir_i & ~mcyc_n_i;
  // Wired-AND of both drivers; released lines are pulled high
  assign bus_o = (dout_i | ~doe_i) & (rd ? mem_q[addr_i[11:14]] : 16'hFFFF);
  // Ready only once the access has had time to settle
  assign ready_o = ~mcyc_n_i & (cnt_q >= (slow_i ? 4'h8 : 4'h2));
  assign sin_o = ^addr_i[3:14];
  always_ff @(posedge core_clk_i) begin
    cnt_q <= mcyc_n_i ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    if (!we_n_i && !mcyc_n_i) begin
      mem_q[addr_i[11:14]] <= dout_i;
    end
  end
  // Serial data is captured as the strobe rises
  always_ff @(posedge strobe_i) begin
    cap_o <= sout_i;
  end
endmodule // mem_model
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the external bus interface
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, mreq, mwe, sreq, sbit, slow, rel_n, wseen;
  logic [14:0] maddr;
  logic [15:0] wdata, rdata;
  logic [1:0]  sop;
  logic [11:0] saddr;
  logic [2:0]  code;
  logic        done, sin_bit, mcyc_n, rdir, we_n, waitp, ready, ack, strobe, sout, sin, cap;
  logic [0:14] addr;
  logic [0:15] dout, doe, bus;
  int          mismatches, checked, cyc;

  cpu_bus_if u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .mem_req_i(mreq), .mem_we_i(mwe),
    .mem_addr_i(maddr), .mem_wdata_i(wdata), .ser_req_i(sreq), .ser_op_i(sop),
    .ser_addr_i(saddr), .ser_out_bit_i(sbit), .ext_code_i(code), .done_o(done),
    .rdata_o(rdata), .ser_in_bit_o(sin_bit), .addr_o(addr), .data_o(dout), .data_oe_o(doe),
    .data_i(bus), .memory_cycle_n_o(mcyc_n), .read_direction_o(rdir), .write_en_n_o(we_n),
    .wait_o(waitp), .ready_i(ready), .bus_release_req_n_i(rel_n), .bus_release_ack_o(ack),
    .serial_io_strobe_o(strobe), .serial_io_out_o(sout), .serial_io_in_i(sin));
  mem_model u_mem (.core_clk_i(clk), .slow_i(slow), .addr_i(addr), .dout_i(dout),
    .doe_i(doe), .mcyc_n_i(mcyc_n), .rdir_i(rdir), .we_n_i(we_n), .bus_o(bus),
    .ready_o(ready), .strobe_i(strobe), .sout_i(sout), .sin_o(sin), .cap_o(cap));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Waits for done under a bound, then drops the request in the done cycle
  task automatic finish();
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk); #2;
      if (waitp === 1'h1) wseen = 1'h1;
      if (done === 1'h1) break;
    end
    chk(done, 1'h1);
    mreq = 1'h0;
    sreq = 1'h0;
  endtask
  task automatic mem_op(input logic we, input logic [14:0] a, input logic [15:0] d);
    @(posedge clk); #2;
    mwe = we; maddr = a; wdata = d; mreq = 1'h1;
    @(posedge clk); #2;
    chk(addr, a);
    chk(mcyc_n, 1'h0);
    chk(rdir, !we);
    chk(we_n, !we);
    chk(doe, we ? 16'hFFFF : 16'h0000);
    if (we) chk(bus, d);
    finish();
  endtask
  task automatic ser_op(input logic [1:0] op, input logic [11:0] a, input logic b,
                        input logic [2:0] c);
    @(posedge clk); #2;
    sop = op; saddr = a; sbit = b; code = c; sreq = 1'h1;
    @(posedge clk); #2;
    chk(mcyc_n, 1'h1);
    chk(addr, {(op == cpu_bus_pkg::SER_OP_EXT) ? c : 3'h0, a});
    chk(strobe, 1'h0);
    if (op != cpu_bus_pkg::SER_OP_INPUT) begin
      @(posedge clk); #2;
      chk(strobe, 1'h1);
    end
    finish();
    chk(strobe, 1'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_memory();
    mem_op(1'h1, 15'h7FF3, 16'hA5C3);
    mem_op(1'h1, 15'h0005, 16'h5A3C);
    mem_op(1'h0, 15'h7FF3, 16'h0000);
    chk(rdata, 16'hA5C3);
    $display("test memory finished");
  endtask
  task automatic t_wait();
    slow = 1'h1; wseen = 1'h0;
    mem_op(1'h0, 15'h0005, 16'h0000);
    chk(rdata, 16'h5A3C);
    chk(wseen, 1'h1);
    slow = 1'h0;
    $display("test wait finished");
  endtask
  task automatic t_serial();
    ser_op(cpu_bus_pkg::SER_OP_OUTPUT, 12'hFFF, 1'h1, 3'h0);
    chk(cap, 1'h1);
    ser_op(cpu_bus_pkg::SER_OP_OUTPUT, 12'h001, 1'h0, 3'h0);
    chk(cap, 1'h0);
    ser_op(cpu_bus_pkg::SER_OP_EXT, 12'h0A5, 1'h0, 3'h5);
    ser_op(cpu_bus_pkg::SER_OP_INPUT, 12'h007, 1'h0, 3'h0);
    chk(sin_bit, 1'h1);
    ser_op(cpu_bus_pkg::SER_OP_INPUT, 12'h123, 1'h0, 3'h0);
    chk(sin_bit, 1'h0);
    $display("test serial finished");
  endtask
  task automatic t_release();
    int i;
    slow = 1'h1;
    @(posedge clk); #2;
    mwe = 1'h0; maddr = 15'h0005; mreq = 1'h1; rel_n = 1'h0;
    finish();
    chk(ack, 1'h0);
    chk(rdata, 16'h5A3C);
    slow = 1'h0;
    for (i = 0; i < 10 && ack !== 1'h1; i++) begin
      @(posedge clk); #2;
    end
    chk(ack, 1'h1);
    chk(addr, 15'h7FFF);
    chk(bus, 16'hFFFF);
    chk(rdir, 1'h1);
    chk({mcyc_n, we_n}, 2'h3);
    maddr = 15'h7FF3; mreq = 1'h1;
    for (i = 0; i < 4; i++) begin
      @(posedge clk); #2;
      chk(done, 1'h0);
    end
    rel_n = 1'h1;
    finish();
    chk(rdata, 16'hA5C3);
    $display("test release finished");
  endtask
  task automatic t_reset();
    @(posedge clk); #2;
    rst_n = 1'h0;
    #2;
    chk(addr, 15'h7FFF);
    chk({mcyc_n, rdir, we_n, ack}, 4'hA);
    chk({strobe, sout, waitp, done}, 4'h4);
    chk(doe, 16'h0000);
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'h1;
    mem_op(1'h0, 15'h0005, 16'h0000);
    chk(rdata, 16'h5A3C);
    $display("test reset finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'h0; mreq = 1'h0; mwe = 1'h0; sreq = 1'h0; sbit = 1'h0; slow = 1'h0;
    rel_n = 1'h1; maddr = 15'h0000; wdata = 16'h0000; sop = 2'h0; saddr = 12'h000;
    code = 3'h0; wseen = 1'h0; mismatches = 0; checked = 0; cyc = 0;
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'h1;
    t_memory();
    t_wait();
    t_serial();
    t_release();
    t_reset();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
